// ===== pkg/sbc_pkg.sv
// Constants and cycle codes for the burst SRAM cycle-decode block.
// Assumes one clock, mclk, and a synchronous active-low reset.
package sbc_pkg;

	// ****************************************************************
	// Widths and layout
	// ****************************************************************
	localparam int SBC_ADDR_W = 21;
	localparam int SBC_LANES = 4;
	localparam int SBC_LANE_BITS = 8;
	localparam int SBC_DQ_W = 36;
	localparam int SBC_PAR_BASE = 32;
	localparam int SBC_BURST_W = 2;
	localparam int SBC_SYNC_STAGES = 3;

	// ****************************************************************
	// Reset values and fixed constants
	// ****************************************************************
	localparam logic [SBC_BURST_W-1:0] SBC_BURST_RST = 2'h0;
	localparam logic [SBC_BURST_W-1:0] SBC_BURST_ONE = 2'h1;
	localparam logic [SBC_LANES-1:0] SBC_LANES_NONE = 4'h0;
	localparam logic [SBC_LANES-1:0] SBC_LANES_ALL = 4'hF;
	localparam logic [SBC_SYNC_STAGES-1:0] SBC_SYNC_RST = 3'h0;

	// ****************************************************************
	// Cycle kinds decoded at each clock rise
	// ****************************************************************
	typedef enum logic [3:0] {
		SBC_CYC_IDLE = 4'b0000,
		SBC_CYC_DESEL = 4'b0001,
		SBC_CYC_BEGIN_RD = 4'b0010,
		SBC_CYC_BEGIN_WR = 4'b0011,
		SBC_CYC_CONT_RD = 4'b0100,
		SBC_CYC_CONT_WR = 4'b0101,
		SBC_CYC_SUSP_RD = 4'b0110,
		SBC_CYC_SUSP_WR = 4'b0111,
		SBC_CYC_SLEEP = 4'b1000
	} sbc_cyc_e;

endpackage

// ===== rtl/sbc_burst_ctr.sv
// Two-bit wrap-around burst counter with linear or interleaved order.
// Assumes load and step come from the cycle decoder on the same clock.
`timescale 1ns/1ps

module sbc_burst_ctr (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [sbc_pkg::SBC_BURST_W-1:0] load_val,
	input wire logic step,
	input wire logic interleave,
	output logic [sbc_pkg::SBC_BURST_W-1:0] next_low
);
	import sbc_pkg::*;

	typedef struct packed {
		logic [SBC_BURST_W-1:0] base;
		logic [SBC_BURST_W-1:0] count;
	} sbc_ctr_s;

	sbc_ctr_s st_ff;
	sbc_ctr_s nxt_st;
	logic [SBC_BURST_W-1:0] cnt_inc;

	// Interleaved order xors the step count into the start address,
	// linear order adds it and wraps inside the 2-bit field
	always_comb begin
		cnt_inc = st_ff.count + SBC_BURST_ONE;
		if (interleave) begin // [R19]
			next_low = st_ff.base ^ cnt_inc;
		end else begin
			next_low = st_ff.base + cnt_inc;
		end
		nxt_st = st_ff;
		if (load) begin // [R19]
			nxt_st.base = load_val;
			nxt_st.count = SBC_BURST_RST;
		end else if (step) begin
			nxt_st.count = cnt_inc;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff <= '{base: SBC_BURST_RST, count: SBC_BURST_RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule

// ===== rtl/sbc_cycle_ctl.sv
// Cycle decoder of a flow-through burst SRAM with common data pins.
// Assumes the controller drives the synchronous pins on mclk; sleep is
// asynchronous and output enable reaches the drivers without the clock.
`timescale 1ns/1ps

// Contract
// R1: Deselect and float data on bad select or strobe combinations.
// R2: While sleep is high, power down, ignore inputs, float data.
// R3: Processor strobe with all selects begins a read, write inputs ignored.
// R4: Controller never writes in the first processor-strobe cycle.
// R5: Controller strobe with selects and write begins write, captures data.
// R6: Controller strobe with selects and no write begins a read.
// R7: No strobe and advance low steps to next burst address.
// R8: Continued write stores at advanced address; selects ignored then.
// R9: No strobe and advance high keeps address; reads or writes again.
// R10: Write when global write low, or qualifier low with a lane low.
// R11: Read when global write high and qualifier or all lanes high.
// R12: Each selected lane alone is written, eight data plus parity bit.
// R13: Output enable acts on drivers asynchronously, never clocked.
// R14: Output enable is blocked during write cycles.
// R15: Read drives all bits when enable low; floats if high or deselected.
// R16: Controller raises output enable before a write starts.
// R17: Global write overrides byte inputs and writes all lanes.
// R18: Controller strobe is ignored when processor strobe is active.
// R19: Burst address from 2-bit counter, interleaved or linear by order pin.
module sbc_cycle_ctl #(
	parameter int ADDR_W = sbc_pkg::SBC_ADDR_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic primary_select_n,
	input wire logic depth_select_hi,
	input wire logic depth_select_n,
	input wire logic sleep_request,
	input wire logic processor_strobe_n,
	input wire logic controller_strobe_n,
	input wire logic advance_n,
	input wire logic global_write_n,
	input wire logic byte_write_qualify_n,
	input wire logic [sbc_pkg::SBC_LANES-1:0] byte_lane_select_n,
	input wire logic burst_order,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic output_enable_n,
	input wire logic [sbc_pkg::SBC_DQ_W-1:0] dq_in,
	input wire logic [sbc_pkg::SBC_DQ_W-1:0] mem_rdata,
	output logic [sbc_pkg::SBC_DQ_W-1:0] dq_out,
	output logic [sbc_pkg::SBC_DQ_W-1:0] dq_oe,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [sbc_pkg::SBC_LANES-1:0] mem_lane_wr,
	output logic [sbc_pkg::SBC_DQ_W-1:0] mem_wdata,
	output sbc_pkg::sbc_cyc_e cycle_kind,
	output logic sleep_active
);
	import sbc_pkg::*;

	typedef struct packed {
		logic [SBC_SYNC_STAGES-1:0] slp;
		logic sleeping;
		logic active;
		logic rd_drive;
		logic rd;
		logic wr;
		logic [SBC_LANES-1:0] lanes;
		logic [ADDR_W-1:0] addr;
		logic [SBC_DQ_W-1:0] wdata;
		sbc_cyc_e cyc;
	} sbc_st_s;

	sbc_st_s st_ff;
	sbc_st_s nxt_st;

	logic sel_ok;
	logic proc_go;
	logic ctrl_go;
	logic write_act;
	logic [SBC_LANES-1:0] lane_en;
	logic ctr_load;
	logic ctr_step;
	logic [SBC_BURST_W-1:0] ctr_next;

	// ****************************************************************
	// Burst address counter
	// ****************************************************************
	sbc_burst_ctr u_burst_ctr (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(ctr_load),
		.load_val(addr[SBC_BURST_W-1:0]),
		.step(ctr_step),
		.interleave(burst_order),
		.next_low(ctr_next)
	);

	// ****************************************************************
	// Cycle decode
	// ****************************************************************
	always_comb begin
		sel_ok = depth_select_hi & ~depth_select_n;
		// Processor strobe counts only with the primary select low
		proc_go = ~processor_strobe_n & ~primary_select_n;
		ctrl_go = ~controller_strobe_n & ~proc_go; // [R18]
		write_act = ~global_write_n | // [R10] [R11]
			(~byte_write_qualify_n & ~(&byte_lane_select_n));
		if (~global_write_n) begin
			lane_en = SBC_LANES_ALL; // [R17]
		end else if (~byte_write_qualify_n) begin
			lane_en = ~byte_lane_select_n; // [R12]
		end else begin
			lane_en = SBC_LANES_NONE;
		end
		ctr_load = 1'b0;
		ctr_step = 1'b0;
		nxt_st = st_ff;
		// Sleep must see both late stages agree before it changes state
		nxt_st.slp = {st_ff.slp[SBC_SYNC_STAGES-2:0], sleep_request};
		if (st_ff.slp[SBC_SYNC_STAGES-1] ==
			st_ff.slp[SBC_SYNC_STAGES-2]) begin
			nxt_st.sleeping = st_ff.slp[SBC_SYNC_STAGES-1];
		end
		nxt_st.rd = 1'b0;
		nxt_st.wr = 1'b0;
		nxt_st.lanes = SBC_LANES_NONE;
		if (st_ff.sleeping) begin
			// Pending bursts are dropped; the data pins stay floated
			nxt_st.cyc = SBC_CYC_SLEEP; // [R2]
			nxt_st.rd_drive = 1'b0;
			nxt_st.active = 1'b0;
		end else if (proc_go) begin
			if (sel_ok) begin
				// Write inputs are ignored on this first cycle
				nxt_st.cyc = SBC_CYC_BEGIN_RD; // [R3] [R4]
				nxt_st.addr = addr;
				nxt_st.rd = 1'b1;
				nxt_st.rd_drive = 1'b1;
				nxt_st.active = 1'b1;
				ctr_load = 1'b1;
			end else begin
				nxt_st.cyc = SBC_CYC_DESEL; // [R1]
				nxt_st.rd_drive = 1'b0;
				nxt_st.active = 1'b0;
			end
		end else if (ctrl_go) begin
			if (sel_ok && ~primary_select_n) begin
				nxt_st.addr = addr;
				nxt_st.active = 1'b1;
				ctr_load = 1'b1;
				if (write_act) begin
					nxt_st.cyc = SBC_CYC_BEGIN_WR; // [R5]
					nxt_st.wr = 1'b1;
					nxt_st.lanes = lane_en;
					nxt_st.wdata = dq_in;
					nxt_st.rd_drive = 1'b0; // [R14]
				end else begin
					nxt_st.cyc = SBC_CYC_BEGIN_RD; // [R6]
					nxt_st.rd = 1'b1;
					nxt_st.rd_drive = 1'b1;
				end
			end else begin
				nxt_st.cyc = SBC_CYC_DESEL; // [R1]
				nxt_st.rd_drive = 1'b0;
				nxt_st.active = 1'b0;
			end
		end else if (st_ff.active) begin
			// Selects are not looked at while no strobe starts an access
			if (~advance_n) begin
				ctr_step = 1'b1; // [R7] [R8]
				nxt_st.addr = {st_ff.addr[ADDR_W-1:SBC_BURST_W], ctr_next};
				nxt_st.cyc = write_act ? SBC_CYC_CONT_WR : SBC_CYC_CONT_RD;
			end else begin
				nxt_st.cyc = write_act ? SBC_CYC_SUSP_WR : SBC_CYC_SUSP_RD; // [R9]
			end
			nxt_st.wr = write_act;
			nxt_st.rd = ~write_act;
			nxt_st.rd_drive = ~write_act; // [R14]
			if (write_act) begin
				nxt_st.lanes = lane_en; // [R12]
				nxt_st.wdata = dq_in;
			end
		end else begin
			nxt_st.cyc = SBC_CYC_IDLE;
			nxt_st.rd_drive = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff <= '{slp: SBC_SYNC_RST, sleeping: 1'b0, active: 1'b0,
				rd_drive: 1'b0, rd: 1'b0, wr: 1'b0, lanes: SBC_LANES_NONE,
				addr: '0, wdata: '0, cyc: SBC_CYC_IDLE};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Output enable bypasses the clock so the pins turn around at once;
	// read data flows through from the array for the same reason
	assign dq_oe = {SBC_DQ_W{st_ff.rd_drive & ~output_enable_n}}; // [R13] [R15]
	assign dq_out = mem_rdata;
	assign mem_addr = st_ff.addr;
	assign mem_rd = st_ff.rd;
	assign mem_wr = st_ff.wr;
	assign mem_lane_wr = st_ff.lanes;
	assign mem_wdata = st_ff.wdata;
	assign cycle_kind = st_ff.cyc;
	assign sleep_active = st_ff.sleeping;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_desel_float: assert property ( // [R1]
		!st_ff.sleeping && primary_select_n && !controller_strobe_n
		|=> cycle_kind == SBC_CYC_DESEL && dq_oe == '0 && !mem_wr)
		else $error("deselect did not float the data pins");

	a_proc_read: assert property ( // [R3]
		!st_ff.sleeping && proc_go && sel_ok
		|=> mem_rd && !mem_wr && mem_addr == $past(addr))
		else $error("processor strobe did not begin a read");

	a_ctrl_write: assert property ( // [R5]
		!st_ff.sleeping && ctrl_go && sel_ok && !primary_select_n
		&& write_act |=> mem_wr && mem_wdata == $past(dq_in))
		else $error("controller write did not capture data");

	a_cont_step: assert property ( // [R7]
		!st_ff.sleeping && st_ff.active && !proc_go && !ctrl_go
		&& !advance_n |=> mem_addr[SBC_BURST_W-1:0] == $past(ctr_next))
		else $error("continue cycle did not advance the address");

	a_susp_hold: assert property ( // [R9]
		!st_ff.sleeping && st_ff.active && !proc_go && !ctrl_go
		&& advance_n |=> $stable(mem_addr) && (mem_wr ^ mem_rd))
		else $error("suspend cycle moved the address");

	a_write_mask: assert property ( // [R14]
		mem_wr |-> dq_oe == '0 ##1 (mem_wr || mem_rd || dq_oe == '0))
		else $error("data pins driven during a write");

	a_global_all: assert property ( // [R17]
		!st_ff.sleeping && !global_write_n && !proc_go
		&& (ctrl_go ? (sel_ok && !primary_select_n) : st_ff.active)
		|=> mem_lane_wr == SBC_LANES_ALL)
		else $error("global write missed a lane");

	a_lane_only: assert property ( // [R12]
		!st_ff.sleeping && global_write_n && !byte_write_qualify_n
		&& st_ff.active && !proc_go && !ctrl_go
		|=> mem_lane_wr == ~$past(byte_lane_select_n))
		else $error("byte write touched an unselected lane");

	a_sleep_quiet: assert property ( // [R2]
		st_ff.sleeping |=> !mem_rd && !mem_wr && dq_oe == '0)
		else $error("access made while asleep");

endmodule

// ===== test/sbc_ctl_model.sv
// Controller model for the burst SRAM pin bus; one cycle per call.
// Assumes the caller invokes drive right after a rising mclk edge.
`timescale 1ns/1ps

module sbc_ctl_model (
	output logic primary_select_n,
	output logic depth_select_hi,
	output logic depth_select_n,
	output logic processor_strobe_n,
	output logic controller_strobe_n,
	output logic advance_n,
	output logic global_write_n,
	output logic byte_write_qualify_n,
	output logic [sbc_pkg::SBC_LANES-1:0] byte_lane_select_n,
	output logic [sbc_pkg::SBC_ADDR_W-1:0] addr,
	output logic output_enable_n,
	output logic [sbc_pkg::SBC_DQ_W-1:0] dq_in
);
	import sbc_pkg::*;
	// ****************************************************************
	// Pin driver
	// ****************************************************************
	initial begin
		{primary_select_n, depth_select_hi, depth_select_n} = 3'h2;
		{processor_strobe_n, controller_strobe_n, advance_n} = 3'h7;
		{global_write_n, byte_write_qualify_n, byte_lane_select_n} = 6'h3F;
		addr = '0;
		output_enable_n = 1'b1;
		dq_in = '0;
	end

	task automatic drive(input logic [2:0] sel, input logic ps_n,
		input logic cs_n, input logic adv_n, input logic [5:0] wrin,
		input logic [SBC_ADDR_W-1:0] a, input logic oe_req,
		input logic [SBC_DQ_W-1:0] d);
		logic wr;
		wr = !wrin[5] || (!wrin[4] && !(&wrin[3:0]));
		{primary_select_n, depth_select_hi, depth_select_n} <= sel;
		processor_strobe_n <= ps_n;
		controller_strobe_n <= cs_n;
		advance_n <= adv_n;
		{global_write_n, byte_write_qualify_n, byte_lane_select_n} <= wrin;
		addr <= a;
		// Enable is released while any write is presented; free later on
		output_enable_n <= wr ? 1'b1 : oe_req;
		// Released data lines must not hold the last value
		dq_in <= wr ? d : ~dq_in;
	endtask

	// Output enable is asynchronous, so it may move between clock edges
	task automatic set_oe(input logic v);
		output_enable_n = v;
	endtask
endmodule

// ===== test/tb_sync_burst_sram_cycle_control.sv
// Self-checking bench for the burst SRAM cycle decoder.
// Assumes sbc_ctl_model drives the pin bus on behalf of the controller.
`timescale 1ns/1ps

module tb_sync_burst_sram_cycle_control;
	import sbc_pkg::*;
	localparam int AW = SBC_ADDR_W;
	logic mclk, sleep_request, burst_order, primary_select_n;
	logic rst_n = 1'b0;
	logic depth_select_hi, depth_select_n, processor_strobe_n;
	logic controller_strobe_n, advance_n, global_write_n;
	logic byte_write_qualify_n, output_enable_n, mem_rd, mem_wr;
	logic sleep_active, order;
	logic act = 1'b0;
	logic [3:0] byte_lane_select_n, mem_lane_wr;
	logic [3:0] e_lanes = 4'h0;
	logic [AW-1:0] addr, mem_addr, e_addr;
	logic [AW-1:0] base = '0;
	logic [1:0] cnt = 2'h0;
	logic [SBC_DQ_W-1:0] dq_in, mem_rdata, dq_out, dq_oe, mem_wdata, e_wd;
	sbc_cyc_e cycle_kind;
	sbc_cyc_e e_kind = SBC_CYC_IDLE;
	int errors = 0;
	int checks_done = 0;
	logic [31:0] r;
	logic [5:0] dsel [5] = '{6'h31, 6'h03, 6'h1B, 6'h05, 6'h3D};

	sbc_ctl_model i_ctl (.primary_select_n, .depth_select_hi,
		.depth_select_n, .processor_strobe_n, .controller_strobe_n,
		.advance_n, .global_write_n, .byte_write_qualify_n,
		.byte_lane_select_n, .addr, .output_enable_n, .dq_in);
	sbc_cycle_ctl #(.ADDR_W(AW)) i_dut (.mclk, .rst_n, .primary_select_n,
		.depth_select_hi, .depth_select_n, .sleep_request,
		.processor_strobe_n, .controller_strobe_n, .advance_n,
		.global_write_n, .byte_write_qualify_n, .byte_lane_select_n,
		.burst_order, .addr, .output_enable_n, .dq_in, .mem_rdata, .dq_out,
		.dq_oe, .mem_addr, .mem_rd, .mem_wr, .mem_lane_wr, .mem_wdata,
		.cycle_kind, .sleep_active);

	// ****************************************************************
	// Compare, predict and drive
	// ****************************************************************
	task automatic cmp_val(input logic [SBC_DQ_W-1:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_kind(input sbc_cyc_e got, exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	function automatic void predict();
		logic wr, sel;
		wr = !global_write_n ||
			(!byte_write_qualify_n && !(&byte_lane_select_n));
		sel = !primary_select_n && depth_select_hi && !depth_select_n;
		e_lanes = !global_write_n ? 4'hF : ~byte_lane_select_n;
		e_wd = dq_in;
		if (!processor_strobe_n && !primary_select_n) begin
			e_kind = sel ? SBC_CYC_BEGIN_RD : SBC_CYC_DESEL;
			wr = 1'b0;
		end else if (!controller_strobe_n) begin
			e_kind = !sel ? SBC_CYC_DESEL : wr ? SBC_CYC_BEGIN_WR
				: SBC_CYC_BEGIN_RD;
		end else if (!act) begin
			e_kind = SBC_CYC_IDLE;
		end else begin
			cnt = cnt + {1'b0, !advance_n};
			e_kind = !advance_n ? (wr ? SBC_CYC_CONT_WR : SBC_CYC_CONT_RD)
				: (wr ? SBC_CYC_SUSP_WR : SBC_CYC_SUSP_RD);
		end
		if (e_kind inside {SBC_CYC_BEGIN_RD, SBC_CYC_BEGIN_WR}) begin
			base = addr;
			cnt = 2'h0;
		end
		act = !(e_kind inside {SBC_CYC_IDLE, SBC_CYC_DESEL});
		if (!wr || !act) e_lanes = 4'h0;
		e_addr = {base[AW-1:2], burst_order ? base[1:0] ^ cnt
			: base[1:0] + cnt};
	endfunction

	task automatic check();
		logic rd, wr;
		rd = e_kind inside {SBC_CYC_BEGIN_RD, SBC_CYC_CONT_RD, SBC_CYC_SUSP_RD};
		wr = e_kind inside {SBC_CYC_BEGIN_WR, SBC_CYC_CONT_WR, SBC_CYC_SUSP_WR};
		cmp_kind(cycle_kind, e_kind);
		cmp_val(SBC_DQ_W'(mem_rd), SBC_DQ_W'(rd));
		cmp_val(SBC_DQ_W'(mem_wr), SBC_DQ_W'(wr));
		cmp_val(SBC_DQ_W'(mem_lane_wr), SBC_DQ_W'(e_lanes));
		if (rd || wr) cmp_val(SBC_DQ_W'(mem_addr), SBC_DQ_W'(e_addr));
		if (wr) cmp_val(mem_wdata, e_wd);
		cmp_val(dq_oe, {SBC_DQ_W{rd & !output_enable_n}});
		cmp_val(dq_out, mem_rdata);
	endtask

	task automatic cyc(input logic [2:0] sel, input logic [2:0] str,
		input logic [5:0] wrin, input logic [31:0] a, input logic oe);
		@(posedge mclk);
		i_ctl.drive(sel, str[2], str[1], str[0], wrin, AW'(a), oe,
			SBC_DQ_W'({$urandom, $urandom}));
		mem_rdata <= SBC_DQ_W'({$urandom, $urandom});
		burst_order <= order;
		#1;
		check();
		predict();
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		#16000;
		errors++;
		summarize();
	end

	initial begin
		sleep_request = 1'b0;
		burst_order = 1'b1;
		order = 1'b1;
		mem_rdata = '0;
		void'($urandom(32'h3331B46C));
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (dsel[i]) begin
			cyc(3'h2, 3'h3, 6'h3F, $urandom, 1'b0);
			cyc(dsel[i][5:3], dsel[i][2:0], 6'h3F, $urandom, 1'b0);
			cyc(3'h2, 3'h6, 6'h3F, 32'h0, 1'b0);
		end
		$display("test deselect done");
		for (int i = 0; i < 16; i++) begin
			cyc(3'h2, 3'h5, {2'h2, 4'(i)}, $urandom, 1'b0);
		end
		$display("test lanes done");
		for (int o = 0; o < 2; o++) begin
			order = o[0];
			cyc(3'h2, 3'h3, 6'h00, $urandom, 1'b1);
			repeat (4) cyc(3'h7, 3'h6, 6'h1F, 32'h0, 1'b0);
			cyc(3'h7, 3'h7, 6'h25, 32'h0, 1'b0);
			cyc(3'h2, 3'h6, 6'h3F, 32'h0, 1'b0);
			cyc(3'h2, 3'h7, 6'h3F, 32'h0, 1'b0);
			i_ctl.set_oe(~output_enable_n);
			#1;
			cmp_val(dq_oe, {SBC_DQ_W{!output_enable_n}});
			i_ctl.set_oe(~output_enable_n);
			#1;
			cmp_val(dq_oe, {SBC_DQ_W{!output_enable_n}});
		end
		$display("test bursts done");
		@(posedge mclk);
		sleep_request <= 1'b1;
		i_ctl.drive(3'h2, 1'b0, 1'b1, 1'b1, 6'h3F, '0, 1'b0, '0);
		repeat (8) begin
			@(posedge mclk);
			#1;
			if (sleep_active === 1'b1) break;
		end
		repeat (4) begin
			@(posedge mclk);
			#1;
			cmp_val(SBC_DQ_W'(sleep_active), SBC_DQ_W'(1'b1));
			cmp_kind(cycle_kind, SBC_CYC_SLEEP);
			cmp_val(SBC_DQ_W'({mem_rd, mem_wr}), '0);
			cmp_val(dq_oe, '0);
		end
		@(posedge mclk);
		sleep_request <= 1'b0;
		i_ctl.drive(3'h2, 1'b1, 1'b1, 1'b1, 6'h3F, '0, 1'b0, '0);
		repeat (8) @(posedge mclk);
		act = 1'b0;
		e_kind = SBC_CYC_IDLE;
		e_lanes = 4'h0;
		$display("test sleep done");
		for (int o = 0; o < 2; o++) begin
			order = o[0];
			cyc(3'h0, 3'h5, 6'h3F, 32'h0, 1'b0);
			repeat (150) begin
				r = $urandom;
				cyc(r[3:0] == 4'h0 ? r[6:4] : 3'h2,
					{r[7] | r[8], r[9] | r[10], r[11]},
					{r[12] | r[13], r[14], r[18:15]}, $urandom, r[19]);
			end
		end
		$display("test random done");
		summarize();
	end
endmodule
